// File: rtl/rsi_reset_init.sv
// Purpose: Puts the core state into its defined post-reset condition
// Assumes: Synchronous active-high reset, 40 MHz clock
// Notes:   Retained state keeps its value; undefined state also holds, except the RAM window, which is inverted
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_init (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic standby_in,
  input wire logic [7:0] pm_data_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_sel_in,
  input wire logic [8:0] wr_data_in,
  input wire logic [8:0] ram_addr_in,
  output logic [12:0] pm_addr_out,
  output logic running_out,
  output logic was_standby_out,
  output logic [12:0] pc_out,
  output logic bank_enable_flag_out,
  output logic interrupt_status_flag_out,
  output logic [1:0] skip_flags_out,
  output logic [3:0] bank_select_reg_out,
  output logic [8:0] source_irq_enable_out,
  output logic global_irq_enable_out,
  output logic [5:0] ext_irq_edge_mode_out,
  output logic [11:0] port_direction_reg_out,
  output logic [11:0] port_oe_out,
  output logic [11:0] port_latch_out,
  output logic [7:0] pullup_select_a_out,
  output logic [7:0] pullup_select_b_out,
  output logic [3:0] pulldown_select_out,
  output logic [3:0] processor_clock_ctrl_out,
  output logic [3:0] system_clock_ctrl_out,
  output logic [3:0] clock_out_mode_out,
  output logic clock_out_enable_out,
  output logic [7:0] bus_serial_ctrl_out,
  output logic [7:0] serial_op_mode_out,
  output logic [7:0] serial_slave_addr_out,
  output logic [7:0] serial_shift_reg_out,
  output logic [15:0] bit_manip_buffer_out,
  output logic carry_flag_out,
  output logic [3:0] gp_reg_out,
  output logic [3:0] ram_data_out
);
  // ---------------------------------------------------------------
  // Write selectors for the normal-run control path
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_IE = 4'h0;
  localparam logic [3:0] SEL_PORT = 4'h1;
  localparam logic [3:0] SEL_CLK = 4'h2;
  localparam logic [3:0] SEL_SER = 4'h3;
  localparam logic [3:0] SEL_DATA = 4'h4;
  localparam logic [3:0] SEL_RAM = 4'h5;
  localparam logic [3:0] SEL_GPR = 4'h6;

  rsi_rom_if rom ();
  rsi_pkg::rsi_state_t state;
  rsi_pkg::rsi_state_t next_state;
  logic [3:0] gpr [0:7];
  logic [3:0] ram [0:rsi_pkg::RAM_DEPTH-1];
  logic [8:0] wipe_idx;
  logic wr_ok;

  // Address inside the window that every reset spoils
  function automatic logic in_lost(input logic [8:0] a);
    in_lost = (a >= rsi_pkg::LOST_LO) && (a <= rsi_pkg::LOST_HI);
  endfunction

  rsi_rom_fetch u_fetch (
    .clk_in(core_clk_in),
    .rst_in(reset_in),
    .rom(rom.fetch),
    .pm_addr_out(pm_addr_out),
    .pm_data_in(pm_data_in)
  );

  rsi_standby_track u_track (
    .clk_in(core_clk_in),
    .rst_in(reset_in),
    .standby_in(standby_in),
    .was_standby_out(was_standby_out)
  );

  // Writes only once vector loading is finished
  assign wr_ok = wr_en_in && !reset_in && (state == rsi_pkg::RSI_RUN);

  // ---------------------------------------------------------------
  // Vector fetch sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    rom.req = 1'b0;
    rom.addr = rsi_pkg::VEC_HI_ADDR;
    case (state)
      rsi_pkg::RSI_IDLE:
      begin
        rom.req = 1'b1;
        rom.addr = rsi_pkg::VEC_HI_ADDR;
        next_state = rsi_pkg::RSI_FETCH_HI;
      end
      rsi_pkg::RSI_FETCH_HI:
      begin
        if (rom.valid)
        begin
          rom.req = 1'b1;
          rom.addr = rsi_pkg::VEC_LO_ADDR;
          next_state = rsi_pkg::RSI_FETCH_LO;
        end
      end
      rsi_pkg::RSI_FETCH_LO:
        if (rom.valid)
          next_state = rsi_pkg::RSI_WIPE;
      rsi_pkg::RSI_WIPE:
        if (wipe_idx == rsi_pkg::LOST_HI)
          next_state = rsi_pkg::RSI_RUN;
      rsi_pkg::RSI_RUN:
        next_state = rsi_pkg::RSI_RUN;
      default:
        next_state = rsi_pkg::RSI_IDLE;
    endcase
  end

  // State register; reset restarts the vector load
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      state <= rsi_pkg::RSI_IDLE;
    else
      state <= next_state;
  end

  // Run indication
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      running_out <= 1'b0;
    else
      running_out <= (next_state == rsi_pkg::RSI_RUN);
  end

  // ---------------------------------------------------------------
  // Program counter and bank enable from the vector
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pc_out <= 13'h0000;
      bank_enable_flag_out <= 1'b0;
    end
    else if (state == rsi_pkg::RSI_FETCH_HI && rom.valid)
    begin
      pc_out[12:8] <= rom.data[rsi_pkg::PC_HI_W-1:0];
      bank_enable_flag_out <= rom.data[rsi_pkg::BANK_EN_BIT];
    end
    else if (state == rsi_pkg::RSI_FETCH_LO && rom.valid)
      pc_out[7:0] <= rom.data;
  end

  // ---------------------------------------------------------------
  // Cleared control state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      interrupt_status_flag_out <= 1'b0;
      skip_flags_out <= rsi_pkg::SKIP_CLR;
      bank_select_reg_out <= rsi_pkg::NIB_CLR;
      source_irq_enable_out <= rsi_pkg::IE_CLR;
      global_irq_enable_out <= 1'b0;
      ext_irq_edge_mode_out <= 6'h00;
    end
    else if (wr_ok && wr_sel_in == SEL_IE)
    begin
      source_irq_enable_out <= wr_data_in;
      global_irq_enable_out <= ~global_irq_enable_out;
      bank_select_reg_out <= wr_data_in[3:0];
      {interrupt_status_flag_out, skip_flags_out, ext_irq_edge_mode_out} <= wr_data_in;
    end
  end

  // Port configuration; output buffers follow direction bits
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      port_direction_reg_out <= 12'h000;
      port_oe_out <= 12'h000;
      port_latch_out <= 12'h000;
      pullup_select_a_out <= rsi_pkg::BYTE_CLR;
      pullup_select_b_out <= rsi_pkg::BYTE_CLR;
      pulldown_select_out <= rsi_pkg::NIB_CLR;
    end
    else
    begin
      port_oe_out <= port_direction_reg_out;
      if (wr_ok && wr_sel_in == SEL_PORT)
      begin
        port_direction_reg_out <= {3'h0, wr_data_in};
        port_latch_out <= {wr_data_in[2:0], wr_data_in};
        {pullup_select_a_out, pullup_select_b_out} <= {2{wr_data_in[7:0]}};
        pulldown_select_out <= wr_data_in[3:0];
      end
    end
  end

  // Clock controls; output enable follows mode bit 3 one cycle late
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      processor_clock_ctrl_out <= rsi_pkg::NIB_CLR;
      system_clock_ctrl_out <= rsi_pkg::NIB_CLR;
      clock_out_mode_out <= rsi_pkg::NIB_CLR;
      clock_out_enable_out <= 1'b0;
    end
    else
    begin
      clock_out_enable_out <= clock_out_mode_out[3];
      if (wr_ok && wr_sel_in == SEL_CLK)
      begin
        processor_clock_ctrl_out <= wr_data_in[3:0];
        system_clock_ctrl_out <= wr_data_in[7:4];
        clock_out_mode_out <= wr_data_in[7:4];
      end
    end
  end

  // Serial control clears
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      bus_serial_ctrl_out <= rsi_pkg::BYTE_CLR;
      serial_op_mode_out <= rsi_pkg::BYTE_CLR;
    end
    else if (wr_ok && wr_sel_in == SEL_SER)
    begin
      bus_serial_ctrl_out <= wr_data_in[7:0];
      serial_op_mode_out <= wr_data_in[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Retained data: no reset branch, so contents hold through reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_in && wr_ok && wr_sel_in == SEL_DATA)
    begin
      serial_slave_addr_out <= wr_data_in[7:0];
      serial_shift_reg_out <= wr_data_in[7:0];
      bit_manip_buffer_out <= {bit_manip_buffer_out[6:0], wr_data_in};
      carry_flag_out <= wr_data_in[0];
    end
  end

  // General registers; running reset leaves them undefined by holding
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_in && wr_ok && wr_sel_in == SEL_GPR)
      gpr[ram_addr_in[2:0]] <= wr_data_in[3:0];
  end

  // Wipe counter walks the spoiled window after each reset
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      wipe_idx <= rsi_pkg::LOST_LO;
    else if (state == rsi_pkg::RSI_WIPE && wipe_idx != rsi_pkg::LOST_HI)
      wipe_idx <= wipe_idx + 9'h001;
  end

  // RAM: window spoiled on any reset, rest held (undefined = held)
  always_ff @(posedge core_clk_in)
  begin
    if (state == rsi_pkg::RSI_WIPE && in_lost(wipe_idx))
      ram[wipe_idx] <= ~ram[wipe_idx];
    else if (wr_ok && wr_sel_in == SEL_RAM)
      ram[ram_addr_in] <= wr_data_in[3:0];
  end

  // Read ports share one index; both answer one cycle after the address
  always_ff @(posedge core_clk_in)
  begin
    gp_reg_out <= gpr[ram_addr_in[2:0]];
    ram_data_out <= ram[ram_addr_in];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_pc_hi;
    @(posedge core_clk_in) disable iff (reset_in)
    (state == rsi_pkg::RSI_FETCH_HI && rom.valid) |=> (pc_out[12:8] == $past(rom.data[4:0]));
  endproperty
  a_pc_hi: assert property (p_pc_hi) else $error("pc high not loaded");

  property p_pc_lo;
    @(posedge core_clk_in) disable iff (reset_in)
    (state == rsi_pkg::RSI_FETCH_LO && rom.valid) |=> (pc_out[7:0] == $past(rom.data));
  endproperty
  a_pc_lo: assert property (p_pc_lo) else $error("pc low not loaded");

  property p_mbe;
    @(posedge core_clk_in) disable iff (reset_in)
    (state == rsi_pkg::RSI_FETCH_HI && rom.valid) |=> (bank_enable_flag_out == $past(rom.data[7]));
  endproperty
  a_mbe: assert property (p_mbe) else $error("bank enable not loaded");

  property p_clr_ctrl;
    @(posedge core_clk_in) $fell(reset_in) |-> (!interrupt_status_flag_out
      && skip_flags_out == 2'h0 && bank_select_reg_out == 4'h0 && ext_irq_edge_mode_out == 6'h00
      && source_irq_enable_out == 9'h000 && !global_irq_enable_out);
  endproperty
  a_clr_ctrl: assert property (p_clr_ctrl) else $error("control not cleared");

  property p_clr_port;
    @(posedge core_clk_in) $fell(reset_in) |-> (port_oe_out == 12'h000 && port_latch_out == 12'h000
      && pullup_select_a_out == 8'h00 && pulldown_select_out == 4'h0);
  endproperty
  a_clr_port: assert property (p_clr_port) else $error("port not cleared");

  property p_clk_off;
    @(posedge core_clk_in) $fell(reset_in) |-> (!clock_out_enable_out && clock_out_mode_out == 4'h0
      && processor_clock_ctrl_out == 4'h0 && serial_op_mode_out == 8'h00);
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock control not cleared");

  property p_hold;
    @(posedge core_clk_in) (reset_in && running_out) |=> ($stable(bit_manip_buffer_out)
      && $stable(serial_slave_addr_out));
  endproperty
  a_hold: assert property (p_hold) else $error("retained data changed in reset");

  property p_boot;
    @(posedge core_clk_in) disable iff (reset_in)
    $fell(reset_in) |-> ##[1:12] running_out;
  endproperty
  a_boot: assert property (p_boot) else $error("vector load too slow");

  c_boot: cover property (@(posedge core_clk_in) $rose(running_out));
  c_sb: cover property (@(posedge core_clk_in) $fell(reset_in) && was_standby_out);
  c_wr: cover property (@(posedge core_clk_in) wr_ok && wr_sel_in == SEL_RAM);
endmodule // rsi_reset_init
`default_nettype wire

// File: common/rsi_pkg.sv
// Purpose: Shared constants and types for the reset state initialiser
// Assumes: 40 MHz core clock, synchronous active-high reset
// Notes:   Widths follow the documented register sizes
package rsi_pkg;
  // ---------------------------------------------------------------
  // Vector table and field positions
  // ---------------------------------------------------------------
  localparam logic [12:0] VEC_HI_ADDR = 13'h0000;
  localparam logic [12:0] VEC_LO_ADDR = 13'h0001;
  localparam int BANK_EN_BIT = 7;
  localparam int PC_HI_W = 5;
  // ---------------------------------------------------------------
  // Data memory window lost on every reset
  // ---------------------------------------------------------------
  localparam logic [8:0] LOST_LO = 9'h0f8;
  localparam logic [8:0] LOST_HI = 9'h0fd;
  localparam int RAM_DEPTH = 512;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] NIB_CLR = 4'h0;
  localparam logic [7:0] BYTE_CLR = 8'h00;
  localparam logic [8:0] IE_CLR = 9'h000;
  localparam logic [1:0] SKIP_CLR = 2'h0;
  localparam int NUM_IE = 9;
  localparam int NUM_PORT = 12;
  // Sequencer states
  typedef enum logic [2:0] {RSI_IDLE, RSI_FETCH_HI, RSI_FETCH_LO, RSI_WIPE, RSI_RUN} rsi_state_t;
endpackage

// File: common/rsi_rom_if.sv
// Purpose: Vector fetch path between sequencer and fetch unit
// Assumes: Program memory answers one cycle after an address
// Notes:   Carries request, address and returned byte
`timescale 1ns/1ps
`default_nettype none
interface rsi_rom_if;
  logic req;
  logic [12:0] addr;
  logic [7:0] data;
  logic valid;
  modport seq (output req, output addr, input data, input valid);
  modport fetch (input req, input addr, output data, output valid);
endinterface
`default_nettype wire

// File: rtl/rsi_rom_fetch.sv
// Purpose: One-cycle program memory fetch for the reset vector
// Assumes: Memory data valid one cycle after address
// Notes:   Registers the returned byte
`timescale 1ns/1ps
`default_nettype none
module rsi_rom_fetch (
  input wire logic clk_in,
  input wire logic rst_in,
  rsi_rom_if.fetch rom,
  output logic [12:0] pm_addr_out,
  input wire logic [7:0] pm_data_in
);
  logic pend;
  // ---------------------------------------------------------------
  // Address launch and data capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pend <= 1'b0;
      rom.valid <= 1'b0;
      rom.data <= rsi_pkg::BYTE_CLR;
      pm_addr_out <= rsi_pkg::VEC_HI_ADDR;
    end
    else
    begin
      pend <= rom.req;
      rom.valid <= pend;
      if (rom.req)
        pm_addr_out <= rom.addr;
      if (pend)
        rom.data <= pm_data_in;
    end
  end
endmodule // rsi_rom_fetch
`default_nettype wire

// File: rtl/rsi_standby_track.sv
// Purpose: Records whether reset came while in standby
// Assumes: Standby level synchronous to the core clock
// Notes:   Value is taken from the last cycle before reset
`timescale 1ns/1ps
`default_nettype none
module rsi_standby_track (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic standby_in,
  output logic was_standby_out
);
  logic last_sb;
  // Sample standby only outside reset so the reset-time value survives
  always_ff @(posedge clk_in)
  begin
    if (!rst_in)
      last_sb <= standby_in;
  end
  // Latch at reset entry; holds through the run until the next reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      was_standby_out <= last_sb;
  end
endmodule // rsi_standby_track
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the reset state initialiser
// Assumes: Nibble targets take the low bits of wr_data_in, except system clock and clock-out mode, which take bits 7:4
// Notes:   Values left undefined by an operating reset are never compared
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic standby_in = 1'b0;
  logic [7:0] pm_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic [3:0] wr_sel_in = 4'h0;
  logic [8:0] wr_data_in = 9'h000;
  logic [8:0] ram_addr_in = 9'h000;
  logic [12:0] pm_addr, pc;
  logic running, was_sb, bank_enable_flag, isf, gie, coe, cy;
  logic [1:0] skip;
  logic [3:0] bank_select_reg, pdn, processor_clock_ctrl, system_clock_ctrl, clock_out_mode, gpr, ram;
  logic [8:0] ie;
  logic [5:0] edge_mode;
  logic [11:0] pdir, poe, plat;
  logic [7:0] pua, pub, bsc, som, ssa, ssr;
  logic [15:0] bmb;
  logic [7:0] rom_hi = 8'h00;
  logic [7:0] rom_lo = 8'h00;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Table rows: vector bytes beside the PC and bank flag they must give
  logic [7:0] row_hi [5] = '{8'h00, 8'hff, 8'h9f, 8'h60, 8'h75};
  logic [7:0] row_lo [5] = '{8'h00, 8'hff, 8'h01, 8'hfe, 8'h3c};
  logic [12:0] row_pc [5] = '{13'h0000, 13'h1fff, 13'h1f01, 13'h00fe, 13'h153c};
  logic row_mbe [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  rsi_reset_init i_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .standby_in(standby_in),
    .pm_data_in(pm_data_in), .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in),
    .wr_data_in(wr_data_in), .ram_addr_in(ram_addr_in), .pm_addr_out(pm_addr),
    .running_out(running), .was_standby_out(was_sb), .pc_out(pc),
    .bank_enable_flag_out(bank_enable_flag), .interrupt_status_flag_out(isf),
    .skip_flags_out(skip), .bank_select_reg_out(bank_select_reg), .source_irq_enable_out(ie),
    .global_irq_enable_out(gie), .ext_irq_edge_mode_out(edge_mode),
    .port_direction_reg_out(pdir), .port_oe_out(poe), .port_latch_out(plat),
    .pullup_select_a_out(pua), .pullup_select_b_out(pub), .pulldown_select_out(pdn),
    .processor_clock_ctrl_out(processor_clock_ctrl), .system_clock_ctrl_out(system_clock_ctrl),
    .clock_out_mode_out(clock_out_mode), .clock_out_enable_out(coe), .bus_serial_ctrl_out(bsc),
    .serial_op_mode_out(som), .serial_slave_addr_out(ssa), .serial_shift_reg_out(ssr),
    .bit_manip_buffer_out(bmb), .carry_flag_out(cy), .gp_reg_out(gpr),
    .ram_data_out(ram)
  );

  // ---------------------------------------------------------------
  // Clock, program memory and hang guard
  // ---------------------------------------------------------------
  // Free running core clock
  initial
  begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // Vector bytes answer half a cycle late, on the falling edge after the address; other places give a spoiled pattern
  always @(negedge core_clk_in)
  begin
    if (pm_addr == 13'h0000)
      pm_data_in <= rom_hi;
    else if (pm_addr == 13'h0001)
      pm_data_in <= rom_lo;
    else
      pm_data_in <= ~pm_data_in;
  end

  // Ceiling well above the fewer than two hundred cycles the run needs
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the vector load and wipe to finish
  task automatic wait_run();
    int n;
    n = 0;
    while (running !== 1'b1 && n < 40)
    begin
      @(negedge core_clk_in);
      n++;
    end
    chk(16'(running), 16'h0001);
  endtask

  // Called at a falling edge; caller lowers the strobe after a burst
  task automatic wr(input logic [3:0] sel, input logic [8:0] a, input logic [8:0] d);
    wr_en_in = 1'b1;
    wr_sel_in = sel;
    ram_addr_in = a;
    wr_data_in = d;
    @(negedge core_clk_in);
  endtask

  // Set selectors 0 to 4 (not RAM or general registers) to ones so a missed clear or a lost retained bit shows up
  task automatic fill_all();
    for (int s = 0; s < 5; s++)
      wr(4'(s), 9'h000, 9'h1ff);
    // Second retained write fills the upper bits of the bit buffer
    wr(4'h4, 9'h000, 9'h1ff);
    wr_en_in = 1'b0;
  endtask

  // Poke puts a write inside the vector load, which must be ignored
  task automatic do_reset(input logic sb, input logic poke);
    @(negedge core_clk_in);
    standby_in = sb;
    @(negedge core_clk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    reset_in = 1'b0;
    standby_in = 1'b0;
    if (poke)
    begin
      wr_en_in = 1'b1;
      wr_sel_in = 4'h0;
      wr_data_in = 9'h1ff;
      @(negedge core_clk_in);
      wr_en_in = 1'b0;
    end
    wait_run();
  endtask

  task automatic check_vec(input logic [12:0] epc, input logic embe);
    chk(16'(pc), 16'(epc));
    chk(16'(bank_enable_flag), 16'(embe));
  endtask

  task automatic check_clear();
    chk(16'(isf), 16'h0000);
    chk(16'(skip), 16'h0000);
    chk(16'(bank_select_reg), 16'h0000);
    chk(16'(ie), 16'h0000);
    chk(16'(gie), 16'h0000);
    chk(16'(edge_mode), 16'h0000);
    chk(16'(pdir), 16'h0000);
    chk(16'(poe), 16'h0000);
    chk(16'(plat), 16'h0000);
    chk(16'({pua, pub}), 16'h0000);
    chk(16'(pdn), 16'h0000);
    chk(16'({processor_clock_ctrl, system_clock_ctrl}), 16'h0000);
    chk(16'({coe, clock_out_mode}), 16'h0000);
    chk(16'({bsc, som}), 16'h0000);
  endtask

  // Address then two edges: the registered read answers after the first, the second only adds margin
  task automatic rd(input logic [8:0] a, input logic sel_gpr, input logic [3:0] exp);
    ram_addr_in = a;
    repeat (2) @(negedge core_clk_in);
    if (sel_gpr)
      chk(16'(gpr), 16'(exp));
    else
      chk(16'(ram), 16'(exp));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge core_clk_in);
    reset_in = 1'b0;
    wait_run();
    // Operating resets over the vector table
    for (int i = 0; i < 5; i++)
    begin
      rom_hi = row_hi[i];
      rom_lo = row_lo[i];
      fill_all();
      do_reset(1'b0, 1'b0);
      check_vec(row_pc[i], row_mbe[i]);
      chk(16'(was_sb), 16'h0000);
      check_clear();
      $display("Test row %0d done", i);
    end
    // Write inside the vector load is refused
    do_reset(1'b0, 1'b1);
    check_clear();
    $display("Test early write done");
    // Standby reset keeps memory outside the spoiled window and registers, clears the rest
    rom_hi = 8'h8a;
    rom_lo = 8'h55;
    wr(4'h5, 9'h0f7, 9'h00a);
    wr(4'h5, 9'h0fe, 9'h003);
    wr(4'h5, 9'h1ff, 9'h006);
    wr(4'h5, 9'h0f8, 9'h005);
    wr(4'h6, 9'h003, 9'h00c);
    fill_all();
    do_reset(1'b1, 1'b0);
    chk(16'(was_sb), 16'h0001);
    chk(16'({ssa, ssr}), 16'hffff);
    chk(bmb, 16'hffff);
    chk(16'(cy), 16'h0001);
    check_vec(13'h0a55, 1'b1);
    check_clear();
    rd(9'h0f7, 1'b0, 4'ha);
    rd(9'h0fe, 1'b0, 4'h3);
    rd(9'h1ff, 1'b0, 4'h6);
    rd(9'h003, 1'b1, 4'hc);
    $display("Test standby reset done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
